// ===== rtl/flash_host_defs.vh
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH
// Command cycle addresses and data
`define UNLOCK1_ADDR     17'h00555
`define UNLOCK2_ADDR     17'h002AA
`define UNLOCK1_DATA     8'hAA
`define UNLOCK2_DATA     8'h55
`define RESET_DATA       8'hF0
`define AUTOSEL_DATA     8'h90
`define PROGRAM_DATA     8'hA0
// Autoselect low address bytes
`define AS_MAKER_ADDR    8'h00
`define AS_PART_ADDR     8'h01
`define AS_PROT_ADDR     8'h02
// Sector number position in the address
`define SECTOR_LSB       14
// Operation codes on op_in
`define OP_READ          3'h0
`define OP_RESET         3'h1
`define OP_AUTOSEL       3'h2
`define OP_PROGRAM       3'h3
`define OP_AS_READ       3'h4
// Strobe phase timing in cycles
`define SETUP_CYCLES     4'h2
`define PULSE_CYCLES     4'h2
`define HOLD_CYCLES      4'h2
`define READ_CYCLES      4'h3
// Write cycles in each sequence
`define RESET_WRITES     3'h1
`define AUTOSEL_WRITES   3'h3
`define PROGRAM_WRITES   3'h4
// Address bit held low on identification reads
`define SEL_FIXED_BIT    6
`endif

// ===== rtl/flash_host.v
// Overview of operation
// - High-voltage path: select pin, fixed low, low bits; flash_host uses the autoselect command instead, with bit 6 held low
// - Write only with select, write low, output high
// - Host issues reset after limit flag or autoselect; flash_host sends it only when op_in requests OP_RESET
// - Byte program takes four write cycles
`include "flash_host_defs.vh"

module flash_host #(
    parameter ADDR_W = 17,
    parameter DATA_W = 8
) (
    input  wire              clk_in,
    input  wire              reset_in,
    input  wire              op_valid_in,
    input  wire [2:0]        op_in,
    input  wire [ADDR_W-1:0] op_addr_in,
    input  wire [DATA_W-1:0] op_data_in,
    input  wire              busy_in,
    input  wire [DATA_W-1:0] byte_lines_in,
    output wire              op_ready_out,
    output reg               done_out,
    output reg  [DATA_W-1:0] rdata_out,
    output reg  [ADDR_W-1:0] addr_out,
    output reg  [DATA_W-1:0] byte_lines_out,
    output reg               byte_lines_oe_n_out,
    output reg               ce_n_out,
    output reg               oe_n_out,
    output reg               we_n_out
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE   = 3'h0;
localparam ST_SETUP  = 3'h1;
localparam ST_PULSE  = 3'h2;
localparam ST_HOLD   = 3'h3;
localparam ST_READ   = 3'h4;
localparam ST_BUSY   = 3'h5;

reg [2:0]        state_q;
reg [2:0]        op_q;
reg [2:0]        cyc_q;
reg [2:0]        ncyc_q;
reg [3:0]        cnt_q;
reg [ADDR_W-1:0] taddr_q;
reg [DATA_W-1:0] tdata_q;
reg [ADDR_W-1:0] ca;
reg [DATA_W-1:0] cd;

assign op_ready_out = (state_q == ST_IDLE);

////////////////////////////////////////////////////////////////////////////////
// Identification reads keep the selector-fixed bit low, so the code
// choice rests on the lowest address bits alone
wire [ADDR_W-1:0] rd_addr;

genvar gi;
generate
    for (gi = 0; gi < ADDR_W; gi = gi + 1) begin : g_rd_addr
        if (gi == `SEL_FIXED_BIT) begin : g_fixed
            assign rd_addr[gi] = taddr_q[gi] & (op_q != `OP_AS_READ);
        end else begin : g_pass
            assign rd_addr[gi] = taddr_q[gi];
        end
    end
endgenerate

// Address and data of the current cycle of a sequence
always @* begin
    ca = taddr_q;
    cd = tdata_q;
    if (op_q == `OP_RESET) begin
        ca = taddr_q;
        cd = `RESET_DATA;
    end else if (op_q == `OP_AUTOSEL || op_q == `OP_PROGRAM) begin
        case (cyc_q)
            3'h0: begin
                ca = `UNLOCK1_ADDR;
                cd = `UNLOCK1_DATA;
            end
            3'h1: begin
                ca = `UNLOCK2_ADDR;
                cd = `UNLOCK2_DATA;
            end
            3'h2: begin
                ca = `UNLOCK1_ADDR;
                cd = (op_q == `OP_AUTOSEL) ? `AUTOSEL_DATA : `PROGRAM_DATA;
            end
            default: begin
                ca = taddr_q;
                cd = tdata_q;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Select and write drop together and rise together, so the device's
// later-fall and first-rise capture points coincide with stable bus values
always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
        state_q             <= ST_IDLE;
        op_q                <= 3'h0;
        cyc_q               <= 3'h0;
        ncyc_q              <= 3'h0;
        cnt_q               <= 4'h0;
        taddr_q             <= {ADDR_W{1'b0}};
        tdata_q             <= {DATA_W{1'b0}};
        done_out            <= 1'b0;
        rdata_out           <= {DATA_W{1'b0}};
        addr_out            <= {ADDR_W{1'b0}};
        byte_lines_out      <= {DATA_W{1'b0}};
        byte_lines_oe_n_out <= 1'b1;
        ce_n_out            <= 1'b1;
        oe_n_out            <= 1'b1;
        we_n_out            <= 1'b1;
    end else begin
        done_out <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (op_valid_in) begin
                    op_q    <= op_in;
                    taddr_q <= op_addr_in;
                    tdata_q <= op_data_in;
                    cyc_q   <= 3'h0;
                    cnt_q   <= 4'h0;
                    // Unknown codes fall back to a plain read
                    case (op_in)
                        `OP_RESET:   ncyc_q <= `RESET_WRITES;
                        `OP_AUTOSEL: ncyc_q <= `AUTOSEL_WRITES;
                        `OP_PROGRAM: ncyc_q <= `PROGRAM_WRITES;
                        default:     ncyc_q <= 3'h0;
                    endcase
                    if (op_in == `OP_RESET || op_in == `OP_AUTOSEL ||
                        op_in == `OP_PROGRAM)
                        state_q <= ST_SETUP;
                    else
                        state_q <= ST_READ;
                end
            end
            ST_SETUP: begin
                addr_out            <= ca;
                byte_lines_out      <= cd;
                byte_lines_oe_n_out <= 1'b0;
                oe_n_out            <= 1'b1;
                cnt_q               <= cnt_q + 4'h1;
                if (cnt_q == `SETUP_CYCLES - 4'h1) begin
                    cnt_q    <= 4'h0;
                    ce_n_out <= 1'b0;
                    we_n_out <= 1'b0;
                    state_q  <= ST_PULSE;
                end
            end
            ST_PULSE: begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `PULSE_CYCLES - 4'h1) begin
                    cnt_q    <= 4'h0;
                    ce_n_out <= 1'b1;
                    we_n_out <= 1'b1;
                    state_q  <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == `HOLD_CYCLES - 4'h1) begin
                    cnt_q               <= 4'h0;
                    byte_lines_oe_n_out <= 1'b1;
                    cyc_q               <= cyc_q + 3'h1;
                    if (cyc_q + 3'h1 != ncyc_q)
                        state_q <= ST_SETUP;
                    else if (op_q == `OP_PROGRAM)
                        state_q <= ST_BUSY;
                    else begin
                        done_out <= 1'b1;
                        state_q  <= ST_IDLE;
                    end
                end
            end
            ST_READ: begin
                // Autoselect reads use sector in upper bits, code in low byte
                addr_out            <= rd_addr;
                byte_lines_oe_n_out <= 1'b1;
                ce_n_out            <= 1'b0;
                oe_n_out            <= 1'b0;
                we_n_out            <= 1'b1;
                cnt_q               <= cnt_q + 4'h1;
                if (cnt_q == `READ_CYCLES - 4'h1) begin
                    cnt_q     <= 4'h0;
                    rdata_out <= byte_lines_in;
                    ce_n_out  <= 1'b1;
                    oe_n_out  <= 1'b1;
                    done_out  <= 1'b1;
                    state_q   <= ST_IDLE;
                end
            end
            ST_BUSY: begin
                // No writes while programming; they would be ignored anyway
                if (!busy_in) begin
                    done_out <= 1'b1;
                    state_q  <= ST_IDLE;
                end
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end

endmodule // flash_host

// ===== verification/flash_host_sva.sv
module flash_host_sva (
    input logic       clk_in,
    input logic       reset_in,
    input logic       op_valid_in,
    input logic [2:0] op_in,
    input logic       op_ready_out,
    input logic       done_out,
    input logic       ce_n_out,
    input logic       oe_n_out,
    input logic       we_n_out,
    input logic       byte_lines_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire t = op_valid_in && op_ready_out;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    write_qual_a: assert property (!we_n_out |-> !ce_n_out && oe_n_out) else $error("wq");
    read_pins_a: assert property (!oe_n_out |-> !ce_n_out && we_n_out) else $error("rp");
    pulse_len_a: assert property ($fell(we_n_out) |=> !we_n_out ##1 we_n_out) else $error("pl");
    read_lat_a: assert property (t && op_in == 3'h0 |-> ##4 done_out) else $error("rl");
    reset_lat_a: assert property (t && op_in == 3'h1 |-> ##7 done_out) else $error("zl");
    ident_lat_a: assert property (t && op_in == 3'h2 |-> ##19 done_out) else $error("il");
    prog_lat_a: assert property (t && op_in == 3'h3 |-> !done_out [*8] ##[18:300] done_out)
        else $error("pg");
    busy_hold_a: assert property (t |=> !op_ready_out [*3]) else $error("bh");
    data_drive_a: assert property (!we_n_out |-> !byte_lines_oe_n_out) else $error("dd");
    read_float_a: assert property (!oe_n_out |-> byte_lines_oe_n_out) else $error("rf");
endmodule // flash_host_sva
bind flash_host flash_host_sva sva_u (.*);

// ===== verification/flash_dev_model.sv
module flash_dev_model #(
    parameter       MAKER = 8'h5A, // Arbitrary identity value
    parameter       PART  = 8'hC3, // Arbitrary identity value
    parameter [7:0] PROT  = 8'h00  // One bit per sector, all clear from the factory
) (
    input  logic        clk_in,
    input  logic        pwr_ok_in,
    input  logic        ce_n_in,
    input  logic        oe_n_in,
    input  logic        we_n_in,
    input  logic [16:0] addr_in,
    input  logic [7:0]  data_in,
    output logic [7:0]  data_out,
    output logic        busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    bit [7:0]  z [0:131071]; // Cleared bits, so a new array reads all ones
    bit [16:0] la;
    int st = 0, n = 0, id = 0;
    wire       wsel = ce_n_in | we_n_in;
    wire       u = la == 17'h00555;
    wire [7:0] a = addr_in[7:0];
    wire [2:0] sec = addr_in[16:14];
    // Low supply drops every sequence and mode
    always @(negedge pwr_ok_in) begin
        st = 0;
        id = 0;
        n = 0;
    end
    always @(negedge wsel) la = addr_in;
    always @(posedge wsel) if (pwr_ok_in && oe_n_in && n == 0) begin
        if (data_in == 8'hF0) id = 0;
        if (st == 0 && u && data_in == 8'hAA) st = 1;
        else if (st == 1 && la == 17'h002AA && data_in == 8'h55) st = 2;
        else if (st == 2 && u && data_in == 8'hA0) st = 3;
        else begin
            if (st == 2 && u && data_in == 8'h90) id = 1;
            if (st == 3 && !PROT[la[16:14]]) z[la] |= ~data_in;
            n = st == 3 ? 8 : 0;
            st = 0;
        end
    end
    assign data_out = ce_n_in | oe_n_in ? {8{clk_in}} ^ 8'h96 : !id ? ~z[addr_in] :
        a == 8'h00 ? MAKER : a == 8'h01 ? PART :
        a == 8'h02 ? {8{PROT[sec]}} : 8'h00;
    assign busy_out = n != 0;
    // Counts off the host's sampling edge, so the countdown never ends at it
    always @(negedge clk_in) if (n > 0) n--;
endmodule // flash_dev_model

// ===== verification/test_flash_host.sv
module test_flash_host;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'h0, reset_in = 1'h1, op_valid_in = 1'h0;
    logic [2:0]  op_in = 3'h0;
    logic [16:0] op_addr_in = 17'h00000;
    logic [7:0]  op_data_in = 8'h00;
    wire         busy_in, op_ready_out, done_out, byte_lines_oe_n_out;
    wire         ce_n_out, oe_n_out, we_n_out;
    wire  [7:0]  byte_lines_in, byte_lines_out, rdata_out, dq;
    wire  [16:0] addr_out;
    int          fails = 0, check_count = 0, cycles = 0;
    assign byte_lines_in = byte_lines_oe_n_out ? dq : byte_lines_out;
    always #25 clk_in = ~clk_in;
    flash_host DUT (
        .clk_in              (clk_in),
        .reset_in            (reset_in),
        .op_valid_in         (op_valid_in),
        .op_in               (op_in),
        .op_addr_in          (op_addr_in),
        .op_data_in          (op_data_in),
        .busy_in             (busy_in),
        .byte_lines_in       (byte_lines_in),
        .op_ready_out        (op_ready_out),
        .done_out            (done_out),
        .rdata_out           (rdata_out),
        .addr_out            (addr_out),
        .byte_lines_out      (byte_lines_out),
        .byte_lines_oe_n_out (byte_lines_oe_n_out),
        .ce_n_out            (ce_n_out),
        .oe_n_out            (oe_n_out),
        .we_n_out            (we_n_out)
    );
    flash_dev_model #(.PROT(8'h80)) dev (.clk_in(clk_in), .pwr_ok_in(!reset_in),
        .ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out), .addr_in(addr_out),
        .data_in(byte_lines_in), .data_out(dq), .busy_out(busy_in));
    // Whole run needs under a thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] g, e);
        check_count++;
        if (g !== e) fails++;
        if (g !== e) $display("Error %0t: got %h want %h", $time, g, e);
    endtask
    task automatic op(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d, e);
        int n = 0;
        @(posedge clk_in);
        {op_in, op_addr_in, op_data_in, op_valid_in} <= {c, a, d, 1'h1};
        @(posedge clk_in);
        op_valid_in <= 1'h0;
        while (done_out !== 1'h1 && n++ < 300) @(posedge clk_in) #1;
        if (n > 300) chk({7'h00, done_out}, 8'h01);
        if (c != 3'h1 && c != 3'h2 && c != 3'h3) chk(rdata_out, e);
    endtask
    task t_prog;
        op(3'h0, 17'h1BFFF, 8'h00, 8'hFF);
        op(3'h3, 17'h1BFFF, 8'h3C, 8'h00);
        op(3'h3, 17'h04000, 8'hC3, 8'h00);
        op(3'h3, 17'h1BFFF, 8'hC3, 8'h00);
        op(3'h0, 17'h1BFFF, 8'h00, 8'h00);
    endtask
    task t_ident;
        op(3'h2, 17'h00000, 8'h00, 8'h00);
        op(3'h4, 17'h1BF00, 8'h00, dev.MAKER);
        op(3'h4, 17'h00001, 8'h00, dev.PART);
        op(3'h4, 17'h0C002, 8'h00, 8'h00);
        op(3'h4, 17'h1C002, 8'h00, 8'hFF);
        op(3'h4, 17'h1BF40, 8'h00, dev.MAKER);
        op(3'h1, 17'h1ABCD, 8'h00, 8'h00);
        op(3'h0, 17'h04000, 8'h00, 8'hC3);
    endtask
    task t_guard;
        op(3'h3, 17'h1C123, 8'h00, 8'h00);
        op(3'h0, 17'h1C123, 8'h00, 8'hFF);
        op(3'h7, 17'h04000, 8'h00, 8'hC3);
    endtask
    task t_lockout;
        op(3'h2, 17'h00000, 8'h00, 8'h00);
        @(posedge clk_in);
        reset_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        chk({5'h00, ce_n_out, oe_n_out, we_n_out}, 8'h07);
        chk({7'h00, op_ready_out}, 8'h01);
        reset_in <= 1'h0;
        op(3'h0, 17'h04000, 8'h00, 8'hC3);
    endtask
    task close_out;
        $display("checks %0d, fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'h0;
        t_prog();
        t_guard();
        t_ident();
        t_lockout();
        close_out();
    end
endmodule // test_flash_host
